// ==== charger_pkg.sv ====
package charger_pkg;

  // Bus address in its 8-bit form; the low bit is the read/write flag.
  localparam logic [7:0]  SLAVE_ADDR_8    = 8'h12;

  // Command codes of the setpoint registers.
  localparam logic [7:0]  CMD_CHG_CURRENT = 8'h14;
  localparam logic [7:0]  CMD_CHG_VOLTAGE = 8'h15;
  localparam logic [7:0]  CMD_IN_CURRENT  = 8'h3F;

  // Significant bits of each setpoint; others read back as zero.
  localparam logic [15:0] CURRENT_MASK    = 16'h3F80;
  localparam logic [15:0] VOLTAGE_MASK    = 16'h7FFE;
  localparam int          CURRENT_LSB_POS = 7;

  // Reset values of the setpoints.
  localparam logic [15:0] SETPOINT_RESET  = 16'h0000;

  // Charge voltage thresholds in millivolts.
  localparam logic [15:0] V_WAKE_MV       = 16'h2328;
  localparam logic [15:0] V_3CELL_LO_MV   = 16'h2EE0;
  localparam logic [15:0] V_3CELL_HI_MV   = 16'h3840;
  localparam logic [15:0] V_4CELL_LO_MV   = 16'h3E80;
  localparam logic [15:0] V_4CELL_HI_MV   = 16'h4B00;

  // Internal voltage step: 18.75 mV is 75/4 mV, 25 mV for four cells.
  localparam logic [19:0] STEP3_X4        = 20'h0004B;
  localparam logic [19:0] STEP4           = 20'h00019;
  localparam logic [6:0]  VDAC_MAX        = 7'h7F;

  // Bits in a byte on the bus.
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

endpackage

// ==== smb_reg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Carries register writes and read data between the bus engine and the bank.
interface smb_reg_if;
  logic        wr_stb;
  logic [7:0]  cmd;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport engine (output wr_stb, output cmd, output wdata, input rdata);
  modport bank   (input wr_stb, input cmd, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== smbus_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
// Slave-only word read/write engine; never drives the clock line.
module smbus_slave
  import charger_pkg::*;
(
  // Clock and reset.
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  // Bus pins.
  input  wire logic i_smb_scl,
  input  wire logic i_smb_sda,
  output logic      o_sda_oe,
  // Register side.
  smb_reg_if.engine reg_if
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_CMD   = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_SKIP  = 3'h5
  } st_t;

  logic [2:0] scl_r, scl_nxt, sda_r, sda_nxt;
  st_t        st_r, st_nxt;
  logic [3:0] bcnt_r, bcnt_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, cmd_r, cmd_nxt, lo_r, lo_nxt;
  logic [1:0] bidx_r, bidx_nxt;
  logic       ackph_r, ackph_nxt, nack_r, nack_nxt, oe_r, oe_nxt, stb_r, stb_nxt;
  logic       rise, fall, start, stop;

  // Two flops synchronise the pins; the third stage only finds edges.
  assign scl_nxt = {scl_r[1:0], i_smb_scl};
  assign sda_nxt = {sda_r[1:0], i_smb_sda};
  assign rise  = scl_r[1] & ~scl_r[2];
  assign fall  = ~scl_r[1] & scl_r[2];
  assign start = scl_r[1] & scl_r[2] & ~sda_r[1] & sda_r[2];
  assign stop  = scl_r[1] & scl_r[2] & sda_r[1] & ~sda_r[2];

  // Byte framing, acknowledge and transmit control.
  always_comb begin
    st_nxt = st_r; bcnt_nxt = bcnt_r; sh_nxt = sh_r; tx_nxt = tx_r;
    cmd_nxt = cmd_r; lo_nxt = lo_r; bidx_nxt = bidx_r; ackph_nxt = ackph_r;
    nack_nxt = nack_r; oe_nxt = oe_r; stb_nxt = 1'b0;
    if (start) begin
      st_nxt = ST_ADDR; bcnt_nxt = 4'h0; ackph_nxt = 1'b0; oe_nxt = 1'b0;
    end else if (stop) begin
      st_nxt = ST_IDLE; oe_nxt = 1'b0;
    end else if (rise && st_r != ST_IDLE && st_r != ST_SKIP) begin
      if (ackph_r) begin
        nack_nxt = sda_r[1]; // Master acknowledge of a transmitted byte.
      end else begin
        sh_nxt = {sh_r[6:0], sda_r[1]};
        tx_nxt = {tx_r[6:0], 1'b0};
        bcnt_nxt = bcnt_r + 4'h1;
      end
    end else if (fall && st_r != ST_IDLE && st_r != ST_SKIP) begin
      if (ackph_r) begin
        ackph_nxt = 1'b0; oe_nxt = 1'b0; bcnt_nxt = 4'h0;
        if (st_r == ST_RDATA) begin
          if (!nack_r && bidx_r != 2'h2) begin
            tx_nxt = (bidx_r == 2'h0) ? reg_if.rdata[7:0] : reg_if.rdata[15:8];
            oe_nxt = ~((bidx_r == 2'h0) ? reg_if.rdata[7] : reg_if.rdata[15]);
          end else begin
            st_nxt = ST_SKIP;
          end
        end
      end else if (bcnt_r == BITS_PER_BYTE) begin
        ackph_nxt = 1'b1; oe_nxt = 1'b0;
        case (st_r)
          ST_ADDR: begin
            if (sh_r[7:1] == SLAVE_ADDR_8[7:1]) begin
              oe_nxt = 1'b1;
              st_nxt = sh_r[0] ? ST_RDATA : ST_CMD;
              bidx_nxt = 2'h0; nack_nxt = 1'b0;
            end else begin
              st_nxt = ST_SKIP;
            end
          end
          ST_CMD: begin
            // Only the three setpoint commands are acknowledged.
            if (sh_r == CMD_CHG_CURRENT || sh_r == CMD_CHG_VOLTAGE ||
                sh_r == CMD_IN_CURRENT) begin
              cmd_nxt = sh_r; oe_nxt = 1'b1; st_nxt = ST_WDATA; bidx_nxt = 2'h0;
            end else begin
              st_nxt = ST_SKIP;
            end
          end
          ST_WDATA: begin
            oe_nxt = (bidx_r != 2'h2); // No error-code byte is accepted.
            if (bidx_r == 2'h0) lo_nxt = sh_r;
            if (bidx_r == 2'h1) stb_nxt = 1'b1;
            if (bidx_r != 2'h2) bidx_nxt = bidx_r + 2'h1;
            else st_nxt = ST_SKIP;
          end
          ST_RDATA: begin
            bidx_nxt = bidx_r + 2'h1; // Master drives the acknowledge.
          end
          default: st_nxt = ST_SKIP;
        endcase
      end else if (st_r == ST_RDATA) begin
        oe_nxt = ~tx_r[7]; // Open drain: pull low for a zero bit.
      end
    end
  end

  // State registers.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_r <= 3'h7; sda_r <= 3'h7; st_r <= ST_IDLE; bcnt_r <= 4'h0;
      sh_r <= 8'h00; tx_r <= 8'h00; cmd_r <= 8'h00; lo_r <= 8'h00;
      bidx_r <= 2'h0; ackph_r <= 1'b0; nack_r <= 1'b0; oe_r <= 1'b0;
      stb_r <= 1'b0;
    end else begin
      scl_r <= scl_nxt; sda_r <= sda_nxt; st_r <= st_nxt; bcnt_r <= bcnt_nxt;
      sh_r <= sh_nxt; tx_r <= tx_nxt; cmd_r <= cmd_nxt; lo_r <= lo_nxt;
      bidx_r <= bidx_nxt; ackph_r <= ackph_nxt; nack_r <= nack_nxt;
      oe_r <= oe_nxt; stb_r <= stb_nxt;
    end
  end

  assign o_sda_oe      = oe_r;
  assign reg_if.wr_stb = stb_r;
  assign reg_if.cmd    = cmd_r;
  assign reg_if.wdata  = {sh_r, lo_r};

endmodule
`default_nettype wire

// ==== charger_smbus_setpoint_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Start charging only inside temperature window.
// - Suspend whenever temperature leaves window; resume inside.
// - Suspend turns off both switch drives.
// - Bus slave only, no error-code byte.
// - Answer at bus address 0x12.
// - Only the three setpoint commands supported.
// - Charge current 16 bits, bits 7-13 count.
// - Charge current valid 0 to 16.256 A.
// - Over-range charge current loses bits 14-15, no clamp; may become zero.
// - Zero charge current disables the charger.
// - Input current limit, same layout as charge.
// - Over-range input current loses bits 14-15, no clamp; may become zero.
// - Zero input current disables the charger.
// - Charge voltage bits 1-14, 2 mV weight.
// - Valid voltages truncate down to internal step.
// - Out-of-range voltage disables, flags, alerts host.
// - Voltage above 19.2 V clamps to maximum.
// - Exactly 9000 mV selects wake-up target.
module charger_smbus_setpoint_regs
  import charger_pkg::*;
(
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  // Bus pins; data is open drain, the clock is input only.
  input  wire logic       i_smb_scl,
  input  wire logic       i_smb_sda,
  output logic            o_smb_sda_out,
  output logic            o_smb_sda_oe,
  // Temperature window comparator result.
  input  wire logic       i_temp_in_window,
  // Switch drive requests from the converter, and gated drives.
  input  wire logic       i_hs_drive_req,
  input  wire logic       i_ls_drive_req,
  output logic            o_hs_drive,
  output logic            o_ls_drive,
  // Decoded setpoints and status.
  output logic            o_charge_enable,
  output logic [6:0]      o_chg_current_code,
  output logic [6:0]      o_in_current_code,
  output logic [6:0]      o_vdac_code,
  output logic            o_vdac_4cell,
  output logic            o_vdac_wake,
  output logic            o_vor_flag,
  output logic            o_host_alert
);

  smb_reg_if reg_if ();

  logic [15:0] cc_r, cc_nxt, cv_r, cv_nxt, icl_r, icl_nxt;
  logic [1:0]  temp_r, temp_nxt;
  logic        en_r, en_nxt, hs_r, hs_nxt, ls_r, ls_nxt, vor_r, vor_nxt;
  logic        four_r, four_nxt, wake_r, wake_nxt, oe_q_r;
  logic [6:0]  vcode_r, vcode_nxt;
  logic [15:0] v_mv;
  logic [19:0] diff3, diff4;
  logic        vor_c;

  smbus_slave u_slave (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_smb_scl (i_smb_scl),
    .i_smb_sda (i_smb_sda),
    .o_sda_oe  (o_smb_sda_oe),
    .reg_if    (reg_if)
  );

  // Register writes keep only significant bits, so reads show zeros there.
  always_comb begin
    cc_nxt  = cc_r;
    cv_nxt  = cv_r;
    icl_nxt = icl_r;
    if (reg_if.wr_stb) begin
      if (reg_if.cmd == CMD_CHG_CURRENT) begin
        cc_nxt = reg_if.wdata & CURRENT_MASK;
      end else if (reg_if.cmd == CMD_CHG_VOLTAGE) begin
        cv_nxt = reg_if.wdata & VOLTAGE_MASK;
      end else if (reg_if.cmd == CMD_IN_CURRENT) begin
        icl_nxt = reg_if.wdata & CURRENT_MASK;
      end
    end
  end

  // Read data mux by command.
  always_comb begin
    if (reg_if.cmd == CMD_CHG_CURRENT) begin
      reg_if.rdata = cc_r;
    end else if (reg_if.cmd == CMD_CHG_VOLTAGE) begin
      reg_if.rdata = cv_r;
    end else if (reg_if.cmd == CMD_IN_CURRENT) begin
      reg_if.rdata = icl_r;
    end else begin
      reg_if.rdata = 16'h0000;
    end
  end

  // Voltage decode: range check, step truncation and clamp.
  assign v_mv  = cv_r;
  assign diff3 = {4'h0, v_mv - V_3CELL_LO_MV};
  assign diff4 = {4'h0, v_mv - V_4CELL_LO_MV};
  assign vor_c = (v_mv != V_WAKE_MV) &&
                 ((v_mv < V_3CELL_LO_MV) ||
                  (v_mv >= V_3CELL_HI_MV && v_mv < V_4CELL_LO_MV));

  always_comb begin
    wake_nxt  = (v_mv == V_WAKE_MV);
    four_nxt  = (v_mv >= V_4CELL_LO_MV);
    vor_nxt   = vor_c;
    vcode_nxt = 7'h00;
    if (v_mv >= V_4CELL_HI_MV) begin
      vcode_nxt = VDAC_MAX;
    end else if (four_nxt) begin
      vcode_nxt = 7'(diff4 / STEP4);
    end else if (!vor_c && !wake_nxt) begin
      vcode_nxt = 7'({diff3[17:0], 2'b00} / STEP3_X4);
    end
  end

  // Charge enable and drive gating; temperature passes two flops first.
  assign temp_nxt = {temp_r[0], i_temp_in_window};
  always_comb begin
    // Bits 14 and 15 are dropped, so over-range values wrap into 0 to 16.256 A.
    en_nxt = (cc_r[13:7] != 7'h00) && (icl_r[13:7] != 7'h00) &&
             !vor_c && temp_r[1];
    hs_nxt = i_hs_drive_req & en_nxt;
    ls_nxt = i_ls_drive_req & en_nxt;
  end

  // State registers.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cc_r <= SETPOINT_RESET; cv_r <= SETPOINT_RESET; icl_r <= SETPOINT_RESET;
      temp_r <= 2'h0; en_r <= 1'b0; hs_r <= 1'b0; ls_r <= 1'b0;
      vor_r <= 1'b0; four_r <= 1'b0; wake_r <= 1'b0; vcode_r <= 7'h00;
      oe_q_r <= 1'b0;
    end else begin
      cc_r <= cc_nxt; cv_r <= cv_nxt; icl_r <= icl_nxt;
      temp_r <= temp_nxt; en_r <= en_nxt; hs_r <= hs_nxt; ls_r <= ls_nxt;
      vor_r <= vor_nxt; four_r <= four_nxt; wake_r <= wake_nxt;
      vcode_r <= vcode_nxt; oe_q_r <= 1'b0;
    end
  end

  assign o_smb_sda_out      = oe_q_r; // Always low when enabled.
  assign o_hs_drive         = hs_r;
  assign o_ls_drive         = ls_r;
  assign o_charge_enable    = en_r;
  assign o_chg_current_code = cc_r[CURRENT_LSB_POS +: 7];
  assign o_in_current_code  = icl_r[CURRENT_LSB_POS +: 7];
  assign o_vdac_code        = vcode_r;
  assign o_vdac_4cell       = four_r;
  assign o_vdac_wake        = wake_r;
  assign o_vor_flag         = vor_r;
  assign o_host_alert       = vor_r;

  // Checks; every property samples on the system clock and sleeps in reset.
  sequence cold_s;
    !temp_r[1];
  endsequence

  // A write strobe for one setpoint; the register must follow one clock later.
  sequence wr_cc_s;
    reg_if.wr_stb && reg_if.cmd == CMD_CHG_CURRENT;
  endsequence

  sequence wr_icl_s;
    reg_if.wr_stb && reg_if.cmd == CMD_IN_CURRENT;
  endsequence

  sequence wr_cv_s;
    reg_if.wr_stb && reg_if.cmd == CMD_CHG_VOLTAGE;
  endsequence

  temp_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cold_s |=> !o_hs_drive && !o_ls_drive && !o_charge_enable)
    else $error("drive active outside temperature window");
  temp_sync_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !i_temp_in_window [*3] |=> !o_charge_enable)
    else $error("charge enabled while too hot or cold");
  zero_cc_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cc_r == 16'h0000 |=> !o_charge_enable)
    else $error("charger enabled with zero charge current");
  zero_icl_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    icl_r == 16'h0000 |=> !o_charge_enable)
    else $error("charger enabled with zero input current");
  vor_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (cv_r >= V_3CELL_HI_MV && cv_r < V_4CELL_LO_MV) |=> o_vor_flag && o_host_alert
    && !o_charge_enable)
    else $error("gap voltage not flagged");
  vclamp_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cv_r >= V_4CELL_HI_MV |=> o_vdac_code == VDAC_MAX && o_vdac_4cell && !o_vor_flag)
    else $error("high voltage not clamped");
  wake_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cv_r == V_WAKE_MV |=> o_vdac_wake && !o_vor_flag)
    else $error("wake voltage not selected");
  cc_store_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    wr_cc_s |=> cc_r == ($past(reg_if.wdata) & CURRENT_MASK))
    else $error("charge current write lost");
  icl_store_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    wr_icl_s |=> o_in_current_code == $past(reg_if.wdata[13:7]))
    else $error("input current write lost");
  cv_store_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    wr_cv_s |=> cv_r == ($past(reg_if.wdata) & VOLTAGE_MASK))
    else $error("charge voltage write lost");
  stb_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    reg_if.wr_stb |=> !reg_if.wr_stb)
    else $error("write strobe longer than one clock");
  drive_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (o_hs_drive || o_ls_drive) |-> o_charge_enable)
    else $error("switch drive without charge enable");
  vor_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (cv_r < V_3CELL_LO_MV && cv_r != V_WAKE_MV) |=> o_vor_flag && o_host_alert
    && !o_charge_enable)
    else $error("low voltage not flagged");
  four_cell_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (cv_r >= V_4CELL_LO_MV && cv_r < V_4CELL_HI_MV) |=> o_vdac_4cell && !o_vor_flag
    && !o_vdac_wake)
    else $error("four-cell voltage not decoded");
  full_scale_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    temp_r[1] && cc_r[13:7] == 7'h7F && icl_r[13:7] != 7'h00 && !vor_c && !reg_if.wr_stb
    |=> o_charge_enable && o_chg_current_code == 7'h7F)
    else $error("full-scale charge current not kept on");

endmodule
`default_nettype wire

// ==== smb_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bus master model; the clock line idles high between frames.
module smb_host
  import charger_pkg::*;
(
  // System clock that times every bus phase.
  input  wire logic i_clk,
  // Resolved data line.
  input  wire logic i_sda,
  // Clock line and data release; 1 lets the pull-up win.
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Waits whole system clocks so every change follows a rising edge.
  task automatic hw(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // One 160 ns bit: data set while low, line sampled mid-high, equal phases.
  task automatic bit_io(input logic b, output logic seen);
    o_sda <= b;
    hw(2);
    o_scl <= 1'b1;
    hw(2);
    seen = i_sda;
    hw(2);
    o_scl <= 1'b0;
    hw(2);
  endtask

  // Start when rise is 0, stop when rise is 1; data moves with clock high.
  task automatic frame_edge(input logic rise);
    o_sda <= ~rise;
    hw(3);
    o_scl <= 1'b1;
    hw(4);
    o_sda <= rise;
    hw(4);
    if (!rise) begin
      o_scl <= 1'b0;
      hw(3);
    end
  endtask

  // Sends a byte MSB first; nak is the level seen in the ninth bit.
  task automatic tx_byte(input logic [7:0] d, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, nak);
  endtask

  // Reads a byte MSB first, then acknowledges it unless it is the last.
  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask

  // Word write: address, command, low byte, high byte.
  task automatic write_word(input logic [7:0] a, input logic [7:0] c,
                            input logic [15:0] d, output logic [3:0] nak);
    frame_edge(1'b0);
    tx_byte(a, nak[3]);
    tx_byte(c, nak[2]);
    tx_byte(d[7:0], nak[1]);
    tx_byte(d[15:8], nak[0]);
    frame_edge(1'b1);
  endtask

  // Word read with a repeated start; the high byte is not acknowledged.
  task automatic read_word(input logic [7:0] c, output logic [15:0] d,
                           output logic [2:0] nak);
    frame_edge(1'b0);
    tx_byte(SLAVE_ADDR_8, nak[2]);
    tx_byte(c, nak[1]);
    frame_edge(1'b0);
    tx_byte(SLAVE_ADDR_8 | 8'h01, nak[0]);
    rx_byte(1'b0, d[7:0]);
    rx_byte(1'b1, d[15:8]);
    frame_edge(1'b1);
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: host model on the bus, random setpoints and corners.
module testbench
  import charger_pkg::*;
();
  logic        i_sys_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        i_temp_in_window = 1'b0;
  logic        i_hs_drive_req = 1'b0;
  logic        i_ls_drive_req = 1'b0;
  logic        scl, host_sda, sda_out, sda_oe, chg_en, v4c, vwk, voltage_out_of_range_flag, alert, hs, ls;
  logic [6:0]  chg_code, in_code, vdac_code;
  logic [15:0] cc, icl, vv;
  int          errors = 0;
  int          samples_checked = 0;
  wire         sda_line = host_sda & ~(sda_oe & ~sda_out);
  logic [15:0] corner [10] = '{16'h0000, 16'h2328, 16'h2EDF, 16'h2EE0, 16'h383F,
                               16'h3840, 16'h3E80, 16'h4B00, 16'hFFFF, 16'hC07F};
  logic [7:0]  cmds [3] = '{CMD_CHG_CURRENT, CMD_CHG_VOLTAGE, CMD_IN_CURRENT};
  logic [15:0] good [3] = '{16'h0400, 16'h3E80, 16'h0400};

  always #10 i_sys_clk = ~i_sys_clk;

  smb_host u_host (.i_clk(i_sys_clk), .i_sda(sda_line), .o_scl(scl), .o_sda(host_sda));

  charger_smbus_setpoint_regs u_dut (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_smb_scl(scl), .i_smb_sda(sda_line),
    .o_smb_sda_out(sda_out), .o_smb_sda_oe(sda_oe), .i_temp_in_window(i_temp_in_window),
    .i_hs_drive_req(i_hs_drive_req), .i_ls_drive_req(i_ls_drive_req), .o_hs_drive(hs),
    .o_ls_drive(ls), .o_charge_enable(chg_en), .o_chg_current_code(chg_code),
    .o_in_current_code(in_code), .o_vdac_code(vdac_code), .o_vdac_4cell(v4c),
    .o_vdac_wake(vwk), .o_vor_flag(voltage_out_of_range_flag), .o_host_alert(alert));

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares a single flag.
  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask

  // Compares a word or code.
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Expected voltage decode as {out_of_range, wake, four_cell, step code}.
  function automatic logic [9:0] vdec(input logic [15:0] v);
    int m;
    m = int'(v & VOLTAGE_MASK);
    if (m == 9000) return 10'h100;
    if (m < 12000 || (m >= 14400 && m < 16000)) return 10'h200;
    if (m < 14400) return {3'b000, 7'(((m - 12000) * 4) / 75)};
    if (m >= 19200) return 10'h0FF;
    return {3'b001, 7'((m - 16000) / 25)};
  endfunction

  // Checks the decoded outputs against the bench copy of the setpoints; DAC outputs only when in range.
  task automatic check_all();
    logic [9:0] d;
    logic       en;
    d  = vdec(vv);
    en = (cc[13:7] != 7'h00) && (icl[13:7] != 7'h00) && !d[9] && i_temp_in_window;
    chk_word("chg_code", 16'(cc[13:7]), 16'(chg_code));
    chk_word("in_code", 16'(icl[13:7]), 16'(in_code));
    chk_bit("vor", d[9], voltage_out_of_range_flag);
    chk_bit("alert", d[9], alert);
    chk_bit("enable", en, chg_en);
    chk_bit("hs", en & i_hs_drive_req, hs);
    chk_bit("ls", en & i_ls_drive_req, ls);
    chk_bit("sda_out", 1'b0, sda_out);
    if (!d[9]) begin
      chk_word("vdac", 16'(d[6:0]), 16'(vdac_code));
      chk_bit("four_cell", d[7], v4c);
      chk_bit("wake", d[8], vwk);
    end
  endtask

  // Sets the temperature window and drive requests, then checks.
  task automatic set_temp(input logic t);
    @(posedge i_sys_clk);
    i_temp_in_window <= t;
    i_hs_drive_req <= 1'($urandom);
    i_ls_drive_req <= 1'($urandom);
    repeat (5) @(posedge i_sys_clk);
    check_all();
  endtask

  // Writes a word, checks the acknowledges, outputs and the read-back.
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d);
    logic [3:0]  nk, en;
    logic [2:0]  rn;
    logic [15:0] r, m;
    if (a != SLAVE_ADDR_8) en = 4'hF;
    else if (c != CMD_CHG_CURRENT && c != CMD_CHG_VOLTAGE && c != CMD_IN_CURRENT) en = 4'h7;
    else en = 4'h0;
    u_host.write_word(a, c, d, nk);
    chk_word("write_nak", 16'(en), 16'(nk));
    m = d & ((c == CMD_CHG_VOLTAGE) ? VOLTAGE_MASK : CURRENT_MASK);
    if (en == 4'h0) begin
      if (c == CMD_CHG_CURRENT) cc = m;
      if (c == CMD_CHG_VOLTAGE) vv = m;
      if (c == CMD_IN_CURRENT) icl = m;
      u_host.read_word(c, r, rn);
      chk_word("read_nak", 16'h0000, 16'(rn));
      chk_word("readback", m, r);
    end
    repeat (2) @(posedge i_sys_clk);
    check_all();
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (90000) @(posedge i_sys_clk);
    errors++;
    final_report();
  end

  initial begin
    cc = SETPOINT_RESET;
    icl = SETPOINT_RESET;
    vv = SETPOINT_RESET;
    void'($urandom(5675));
    repeat (10) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    check_all();
    for (int k = 0; k < 3; k++) wr(SLAVE_ADDR_8, cmds[k], good[k]);
    set_temp(1'b0);
    set_temp(1'b1);
    // Refused frames leave every setpoint untouched.
    wr(8'h14, CMD_CHG_CURRENT, 16'h0000);
    wr(SLAVE_ADDR_8, 8'h11, 16'h0000);
    wr(SLAVE_ADDR_8, 8'h16, 16'h0000);
    // Boundary values on each register while the others hold good values.
    for (int k = 0; k < 3; k++) begin
      foreach (corner[i]) wr(SLAVE_ADDR_8, cmds[k], corner[i]);
      wr(SLAVE_ADDR_8, cmds[k], good[k]);
    end
    // Random settings mixed with random temperature changes.
    repeat (14) begin
      wr(SLAVE_ADDR_8, cmds[$urandom_range(0, 2)], 16'($urandom));
      set_temp(1'($urandom));
    end
    final_report();
  end
endmodule
`default_nettype wire
